// ===== rtl/smh_pkg.sv
// shared constants and types for the two-wire register-port host
package smh_pkg;
  // system clock rate in kHz (100 MHz)
  localparam int CLK_KHZ = 100000;
  // legal bus clock range and the rate used unless overridden
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_MIN_KHZ = 10;
  localparam int SCL_DEF_KHZ = 100;
  // quarter-bit counter width, enough for the slowest legal rate
  localparam int QTR_W = 12;
  // client address of the standard device variant
  localparam logic [6:0] CLIENT_ADDR = 7'h57;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // bit slot index of the acknowledge after eight data bits
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // quarters of one bit: clock low, low, released, high
  localparam logic [1:0] Q_SETUP = 2'h1;
  localparam logic [1:0] Q_RELEASE = 2'h2;
  localparam logic [1:0] Q_SAMPLE = 2'h3;
  // longest clock-low wait before giving up, in ms and cycles
  localparam int CLK_LOW_MS = 30;
  localparam int CLK_LOW_CYC = CLK_LOW_MS * CLK_KHZ;
  localparam logic [7:0] BYTE_IDLE = 8'hff;

  typedef enum {ST_IDLE, ST_START, ST_BIT, ST_FETCH, ST_STOP} smh_state_t;
  typedef enum {PH_ADDR, PH_PTR, PH_WDATA, PH_RADDR, PH_RDATA} smh_phase_t;
endpackage

// ===== rtl/smh_line_if.sv
// synchronised bus line levels passed from the sampler to the host core
`timescale 1ns/1ps
interface smh_line_if;
  logic sclLvl;
  logic sdaLvl;
  logic strapLvl;
  logic busBusy;
  modport sync (output sclLvl, output sdaLvl, output strapLvl,
    output busBusy);
  modport host (input sclLvl, input sdaLvl, input strapLvl,
    input busBusy);
endinterface

// ===== rtl/smh_line_sync.sv
// two-flop synchroniser for the bus pins plus start and stop watch
`timescale 1ns/1ps
module smh_line_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclPin,
  input wire logic sdaPin,
  input wire logic strapPin,
  smh_line_if.sync lines
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [1:0] prev_q;
  logic busy_q;
  logic startSeen;
  logic stopSeen;

  // first stage feeds only the second; clock and data idle high after reset, strap low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 3'h6;
      sync_q <= 3'h6;
    end else begin
      meta_q <= {sclPin, sdaPin, strapPin};
      sync_q <= meta_q;
    end
  end

  // one more stage of the settled levels for edge finding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 2'h3;
    end else begin
      prev_q <= sync_q[2:1];
    end
  end

  // data edges while the clock stays high mark start and stop
  assign startSeen = sync_q[2] && prev_q[1] && prev_q[0] && !sync_q[1];
  assign stopSeen = sync_q[2] && prev_q[1] && !prev_q[0] && sync_q[1];

  // bus is busy from a start until a stop, ours or anyone's
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (startSeen) begin
      busy_q <= 1'b1;
    end else if (stopSeen) begin
      busy_q <= 1'b0;
    end
  end

  assign lines.sclLvl = sync_q[2];
  assign lines.sdaLvl = sync_q[1];
  assign lines.strapLvl = sync_q[0];
  assign lines.busBusy = busy_q;
endmodule

// ===== rtl/smh_host.sv
// two-wire host that reads and writes the power switch byte registers
`timescale 1ns/1ps
// How it works
// RULE1 - start: data falls while clock high
// RULE2 - first byte: seven address bits, direction bit
// RULE3 - device answers only address 57h
// RULE4 - bytes are eight bits, msb first
// RULE5 - device acks each byte it receives
// RULE6 - host acks read bytes except the last
// RULE7 - stop: data rises while clock high
// RULE8 - device never stretches; host tolerates stretching
// RULE9 - device resets after clock low 30 ms
// RULE10 - device resets after lines idle 200 us
// RULE11 - device time-outs disabled until software enables
// RULE12 - bus clock between 10 and 400 kHz
// RULE13 - block transfers carry no byte count
// RULE14 - write: address, pointer, data bytes, stop
// RULE15 - read: pointer, repeated start, data, nack
// RULE16 - block write advances pointer per ack
// RULE17 - block read returns contiguous registers
// RULE18 - pointer wraps from FFh to 00h
// RULE19 - pointer-only write just loads pointer
// RULE20 - read without pointer uses current pointer
// RULE21 - strapped stand-alone device gets no traffic
// RULE22 - device filters lines before edge detection
module smh_host #(
  parameter int SCL_KHZ = smh_pkg::SCL_DEF_KHZ,
  parameter int LOW_TIMEOUT_CYC = smh_pkg::CLK_LOW_CYC,
  parameter int LEN_W = 8,
  parameter logic [6:0] TARGET_ADDR = smh_pkg::CLIENT_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic cmdSetPtr,
  input wire logic [7:0] cmdPtr,
  input wire logic [LEN_W-1:0] cmdLen,
  output logic cmdReady,
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrTake,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done,
  output logic nackErr,
  output logic stuckErr,
  input wire logic busClockPinIn,
  output logic busClockPinOut,
  output logic busClockPinOe,
  input wire logic busDataIn,
  output logic busDataOut,
  output logic busDataOe,
  input wire logic commModeStrapPin
);
  // out-of-range rates are clamped into the legal window
  localparam int RATE = (SCL_KHZ > smh_pkg::SCL_MAX_KHZ) ?
    smh_pkg::SCL_MAX_KHZ : ((SCL_KHZ < smh_pkg::SCL_MIN_KHZ) ?
    smh_pkg::SCL_MIN_KHZ : SCL_KHZ); // RULE12
  // a quarter bit rounds up, so the bus never runs too fast
  localparam int QTR = (smh_pkg::CLK_KHZ + 4 * RATE - 1) / (4 * RATE);
  localparam int WAIT_W = $clog2(LOW_TIMEOUT_CYC + 1);
  localparam int QW = smh_pkg::QTR_W;

  smh_line_if lines ();

  smh_line_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .sclPin(busClockPinIn),
    .sdaPin(busDataIn),
    .strapPin(commModeStrapPin),
    .lines(lines)
  );

  smh_pkg::smh_state_t state_q;
  smh_pkg::smh_phase_t phase_q;
  logic [1:0] qIdx_q;
  logic [QW-1:0] qCnt_q;
  logic [WAIT_W-1:0] waitCnt_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [LEN_W-1:0] len_q;
  logic rd_q;
  logic setPtr_q;
  logic nackFlag_q;
  logic cmdReady_q;
  logic wrTake_q;
  logic [7:0] rdData_q;
  logic rdValid_q;
  logic done_q;
  logic nackErr_q;
  logic stuckErr_q;
  logic busClockOe_q;
  logic busDataOe_q;
  logic drvLvl_q;
  logic active;
  logic stallScl;
  logic tick;
  logic lastQ;
  logic byteEnd;
  logic stuck;
  logic rxByte;
  logic bitDrive;
  logic accept;
  logic sclOePrev_q;
  logic [QW+1:0] sclRun_q;

  assign active = state_q == smh_pkg::ST_START ||
    state_q == smh_pkg::ST_BIT || state_q == smh_pkg::ST_STOP;
  // a released clock held low by the far side freezes the quarter
  assign stallScl = qIdx_q == smh_pkg::Q_RELEASE && !lines.sclLvl; // RULE8
  assign tick = active && !stallScl && qCnt_q == QW'(QTR - 1);
  assign lastQ = tick && qIdx_q == smh_pkg::Q_SAMPLE;
  assign byteEnd = state_q == smh_pkg::ST_BIT && lastQ &&
    bitCnt_q == smh_pkg::ACK_SLOT;
  assign stuck = active && stallScl &&
    waitCnt_q == WAIT_W'(LOW_TIMEOUT_CYC - 1);
  assign rxByte = phase_q == smh_pkg::PH_RDATA;
  assign accept = cmdValid && cmdReady_q;

  // level to put on data in a bit: tx data, or our ack on reads
  always_comb begin
    if (bitCnt_q != smh_pkg::ACK_SLOT) begin
      bitDrive = !rxByte && !shift_q[7]; // RULE4
    end else begin
      bitDrive = rxByte && len_q != LEN_W'(1); // RULE6
    end
  end

  // quarter-bit timebase, held while the clock is being stretched
  always_ff @(posedge clk) begin
    if (!rst_n || !active || stuck) begin
      qCnt_q <= '0;
      qIdx_q <= 2'h0;
    end else if (tick) begin
      qCnt_q <= '0;
      qIdx_q <= qIdx_q + 2'h1;
    end else if (!stallScl) begin
      qCnt_q <= qCnt_q + QW'(1);
    end
  end

  // bounds the stretch wait so a stuck clock cannot hang the host
  always_ff @(posedge clk) begin
    if (!rst_n || !(active && stallScl) || stuck) begin
      waitCnt_q <= '0;
    end else begin
      waitCnt_q <= waitCnt_q + WAIT_W'(1);
    end
  end

  // how long the clock drive has held its level; starts saturated so
  // the idle time before the first frame counts as long enough
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclOePrev_q <= 1'b0;
      sclRun_q <= '1;
    end else begin
      sclOePrev_q <= busClockOe_q;
      if (busClockOe_q != sclOePrev_q) begin
        sclRun_q <= (QW+2)'(1);
      end else if (!sclRun_q[QW+1]) begin
        sclRun_q <= sclRun_q + (QW+2)'(1);
      end
    end
  end

  // transaction sequencer: frames, byte phases and acknowledges
  always_ff @(posedge clk) begin
    if (!rst_n || stuck) begin
      state_q <= smh_pkg::ST_IDLE;
      phase_q <= smh_pkg::PH_ADDR;
      bitCnt_q <= 4'h0;
      shift_q <= smh_pkg::BYTE_IDLE;
      ptr_q <= 8'h00;
      len_q <= '0;
      rd_q <= 1'b0;
      setPtr_q <= 1'b0;
      nackFlag_q <= 1'b0;
    end else begin
      case (state_q)
        smh_pkg::ST_IDLE: begin
          if (accept) begin
            state_q <= smh_pkg::ST_START;
            phase_q <= smh_pkg::PH_ADDR;
            rd_q <= cmdRead;
            // a write always carries the pointer byte
            setPtr_q <= cmdSetPtr || !cmdRead;
            ptr_q <= cmdPtr;
            len_q <= (cmdRead && cmdLen == '0) ? LEN_W'(1) : cmdLen;
            nackFlag_q <= 1'b0;
          end
        end
        smh_pkg::ST_START: begin
          if (lastQ) begin
            state_q <= smh_pkg::ST_BIT;
            bitCnt_q <= 4'h0;
            if (phase_q == smh_pkg::PH_PTR) begin
              phase_q <= smh_pkg::PH_RADDR;
              shift_q <= {TARGET_ADDR, smh_pkg::DIR_READ}; // RULE15
            end else begin
              shift_q <= {TARGET_ADDR, rd_q && !setPtr_q}; // RULE2
            end
          end
        end
        smh_pkg::ST_FETCH: begin
          // data follows the pointer directly, no count byte
          if (wrValid) begin
            state_q <= smh_pkg::ST_BIT;
            shift_q <= wrData; // RULE13
            bitCnt_q <= 4'h0;
          end
        end
        smh_pkg::ST_STOP: begin
          if (lastQ) begin
            state_q <= smh_pkg::ST_IDLE;
          end
        end
        smh_pkg::ST_BIT: begin
          if (lastQ && bitCnt_q != smh_pkg::ACK_SLOT) begin
            shift_q <= {shift_q[6:0], lines.sdaLvl}; // RULE4
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (lastQ) begin
            bitCnt_q <= 4'h0;
            if (!rxByte && lines.sdaLvl) begin
              // no ack from the device: close the frame
              nackFlag_q <= 1'b1; // RULE5
              state_q <= smh_pkg::ST_STOP;
            end else begin
              case (phase_q)
                smh_pkg::PH_ADDR: begin
                  if (rd_q && !setPtr_q) begin
                    phase_q <= smh_pkg::PH_RDATA; // RULE20
                  end else begin
                    phase_q <= smh_pkg::PH_PTR;
                    shift_q <= ptr_q;
                  end
                end
                smh_pkg::PH_PTR: begin
                  if (rd_q) begin
                    state_q <= smh_pkg::ST_START; // RULE15
                  end else if (len_q == '0) begin
                    state_q <= smh_pkg::ST_STOP; // RULE14
                  end else begin
                    phase_q <= smh_pkg::PH_WDATA;
                    state_q <= smh_pkg::ST_FETCH;
                  end
                end
                smh_pkg::PH_WDATA: begin
                  len_q <= len_q - LEN_W'(1);
                  if (len_q == LEN_W'(1)) begin
                    state_q <= smh_pkg::ST_STOP; // RULE14
                  end else begin
                    state_q <= smh_pkg::ST_FETCH;
                  end
                end
                smh_pkg::PH_RADDR: begin
                  phase_q <= smh_pkg::PH_RDATA;
                end
                smh_pkg::PH_RDATA: begin
                  len_q <= len_q - LEN_W'(1);
                  if (len_q == LEN_W'(1)) begin
                    state_q <= smh_pkg::ST_STOP; // RULE6
                  end
                end
                default: begin
                  state_q <= smh_pkg::ST_STOP;
                end
              endcase
            end
          end
        end
        default: begin
          state_q <= smh_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // open-drain drives; data moves in the middle of clock low, except start and stop, which move it while clock is high
  always_ff @(posedge clk) begin
    if (!rst_n || stuck) begin
      busClockOe_q <= 1'b0;
      busDataOe_q <= 1'b0;
    end else begin
      case (state_q)
        smh_pkg::ST_START: begin
          busClockOe_q <= qIdx_q < smh_pkg::Q_RELEASE;
          if (qIdx_q == smh_pkg::Q_SETUP) begin
            busDataOe_q <= 1'b0;
          end else if (qIdx_q == smh_pkg::Q_SAMPLE) begin
            busDataOe_q <= 1'b1; // RULE1
          end
        end
        smh_pkg::ST_BIT: begin
          busClockOe_q <= qIdx_q < smh_pkg::Q_RELEASE;
          if (qIdx_q == smh_pkg::Q_SETUP) begin
            busDataOe_q <= bitDrive;
          end
        end
        smh_pkg::ST_FETCH: begin
          busClockOe_q <= 1'b1;
        end
        smh_pkg::ST_STOP: begin
          busClockOe_q <= qIdx_q < smh_pkg::Q_RELEASE;
          if (qIdx_q == smh_pkg::Q_SETUP) begin
            busDataOe_q <= 1'b1;
          end else if (qIdx_q == smh_pkg::Q_SAMPLE) begin
            busDataOe_q <= 1'b0; // RULE7
          end
        end
        default: begin
          busClockOe_q <= 1'b0;
          busDataOe_q <= 1'b0;
        end
      endcase
    end
  end

  // user-side handshakes; no new command is taken while the device is strapped stand-alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdReady_q <= 1'b0;
      wrTake_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= 8'h00;
      done_q <= 1'b0;
      nackErr_q <= 1'b0;
      stuckErr_q <= 1'b0;
      drvLvl_q <= 1'b0;
    end else begin
      cmdReady_q <= state_q == smh_pkg::ST_IDLE && !accept &&
        !lines.strapLvl && !lines.busBusy; // RULE21
      wrTake_q <= state_q == smh_pkg::ST_FETCH && wrValid && !stuck;
      rdValid_q <= byteEnd && rxByte;
      if (byteEnd && rxByte) begin
        rdData_q <= shift_q;
      end
      done_q <= (state_q == smh_pkg::ST_STOP && lastQ) || stuck;
      nackErr_q <= state_q == smh_pkg::ST_STOP && lastQ && nackFlag_q;
      stuckErr_q <= stuck;
      drvLvl_q <= 1'b0; // the pins are only ever pulled low
    end
  end

  assign cmdReady = cmdReady_q;
  assign wrTake = wrTake_q;
  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign done = done_q;
  assign nackErr = nackErr_q;
  assign stuckErr = stuckErr_q;
  assign busClockPinOut = drvLvl_q;
  assign busClockPinOe = busClockOe_q;
  assign busDataOut = drvLvl_q;
  assign busDataOe = busDataOe_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_start_cond;
    $rose(busDataOe_q) && state_q == smh_pkg::ST_START
      |-> !busClockOe_q && lines.sclLvl;
  endproperty
  a_start_cond: assert property (p_start_cond) // RULE1
    else $error("start pulled data low without clock high");

  property p_addr_byte;
    $past(state_q) == smh_pkg::ST_START && state_q == smh_pkg::ST_BIT
      |-> shift_q[7:1] == TARGET_ADDR && shift_q[0] ==
      (phase_q == smh_pkg::PH_RADDR || (rd_q && !setPtr_q));
  endproperty
  a_addr_byte: assert property (p_addr_byte) // RULE2
    else $error("address byte or direction bit wrong");

  property p_msb_first;
    state_q == smh_pkg::ST_BIT && lastQ && bitCnt_q < 4'h7
      |=> shift_q[7] == $past(shift_q[6]) &&
      bitCnt_q == $past(bitCnt_q) + 4'h1;
  endproperty
  a_msb_first: assert property (p_msb_first) // RULE4
    else $error("byte not shifted msb first");

  property p_read_ack;
    state_q == smh_pkg::ST_BIT && rxByte && bitCnt_q == smh_pkg::ACK_SLOT &&
      qIdx_q == smh_pkg::Q_RELEASE |-> busDataOe_q == (len_q != LEN_W'(1));
  endproperty
  a_read_ack: assert property (p_read_ack) // RULE6
    else $error("read ack or final nack wrong");

  property p_stop_cond;
    $fell(busDataOe_q) && $past(state_q) == smh_pkg::ST_STOP
      |-> !busClockOe_q ##1 done_q || state_q == smh_pkg::ST_STOP;
  endproperty
  a_stop_cond: assert property (p_stop_cond) // RULE7
    else $error("stop released data with clock low");

  // each clock level the host drives lasts at least two quarters
  property p_rate;
    qCnt_q < QW'(QTR) &&
      (busClockOe_q == sclOePrev_q || sclRun_q >= (QW+2)'(2 * QTR));
  endproperty
  a_rate: assert property (p_rate) // RULE12
    else $error("bus clock phase shorter than the rate allows");

  property p_wr_take;
    wrTake_q |-> state_q == smh_pkg::ST_BIT && bitCnt_q == 4'h0 &&
      shift_q == $past(wrData) && phase_q == smh_pkg::PH_WDATA;
  endproperty
  a_wr_take: assert property (p_wr_take) // RULE13
    else $error("write data not sent right after pointer");

  property p_ptr_only;
    byteEnd && phase_q == smh_pkg::PH_PTR && !lines.sdaLvl && !rd_q &&
      len_q == '0 |=> state_q == smh_pkg::ST_STOP;
  endproperty
  a_ptr_only: assert property (p_ptr_only) // RULE14
    else $error("pointer-only write did not stop");

  property p_rstart;
    byteEnd && phase_q == smh_pkg::PH_PTR && !lines.sdaLvl && rd_q
      |=> state_q == smh_pkg::ST_START ##1 busClockOe_q;
  endproperty
  a_rstart: assert property (p_rstart) // RULE15
    else $error("read did not repeat start after pointer");

  property p_strap;
    lines.strapLvl |=> !cmdReady_q;
  endproperty
  a_strap: assert property (p_strap) // RULE21
    else $error("command offered to stand-alone device");
endmodule

// ===== rtl/smh_host_fix.sv
// spare source slot for the host block: no module lives here

// ===== verif/smh_dev_model.sv
// behavioural register-port device answering the host on the two wires
`timescale 1ns/1ps
module smh_dev_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [6:0] addr,
  input wire logic strap,
  input wire logic holdClk,
  output logic sclOe,
  output logic sdaOe
);
  logic [7:0] regs [256];
  logic [7:0] ptr = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] addrByte = 8'h00;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic needPtr = 1'b0;
  logic hold = 1'b0;
  int bitN = 0;
  int ackCnt = 0;

  // a stretch asked for by a scenario only starts once the host has
  // pulled the clock low, as a real stretching part would do it
  always @(holdClk, scl) begin
    if (!holdClk) begin
      hold = 1'b0;
    end else if (scl === 1'b0) begin
      hold = 1'b1;
    end
  end
  assign sclOe = hold;

  initial begin
    sdaOe = 1'b0;
    for (int i = 0; i < 256; i++) regs[i] = 8'h00;
  end

  // data edges while the clock is high open or close a frame; time-outs
  // stay off from reset, so no stretch or idle time ever drops a frame
  always @(sda) begin
    if (scl === 1'b1) begin
      act = !sda;
      bitN = 0;
      first = 1'b1;
      if (!sda) ackCnt = 0;
      sdaOe <= #50 1'b0;
    end
  end

  // bits are taken msb first on the rising clock
  always @(posedge scl) begin
    if (act) begin
      if (bitN < 8 && !(rd && !first)) rx = {rx[6:0], sda};
      if (bitN == 8 && rd && !first) begin
        if (sda) begin
          act = 1'b0;
        end else begin
          ackCnt++;
          ptr = ptr + 8'h01;
        end
      end
      bitN++;
    end
  end

  // data moves only while the clock is low, late enough to keep hold time
  always @(negedge scl) begin
    if (act && bitN == 8) begin
      if (first) begin
        addrByte = rx;
        if (rx[7:1] == addr && !strap) begin
          rd = rx[0];
          needPtr = !rx[0];
          sdaOe <= #50 1'b1;
        end else begin
          act = 1'b0;
        end
      end else if (!rd) begin
        if (needPtr) begin
          ptr = rx;
        end else begin
          regs[ptr] = rx;
          ptr = ptr + 8'h01;
        end
        needPtr = 1'b0;
        sdaOe <= #50 1'b1;
      end else begin
        sdaOe <= #50 1'b0;
      end
    end else if (act && bitN == 9) begin
      bitN = 0;
      first = 1'b0;
      tx = regs[ptr];
      sdaOe <= #50 (rd && !regs[ptr][7]);
    end else if (act && rd && !first && bitN < 8) begin
      sdaOe <= #50 !tx[7-bitN];
    end
  end
endmodule

// ===== verif/test_smh_host.sv
// self-checking bench: host core against the behavioural device
`timescale 1ns/1ps
module test_smh_host;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdRead = 1'b0;
  logic cmdSetPtr = 1'b0;
  logic [7:0] cmdPtr = 8'h00;
  logic [7:0] cmdLen = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrValid = 1'b0;
  logic strap = 1'b0;
  logic holdClk = 1'b0;
  logic [6:0] devAddr = 7'h57;
  logic cmdReady, wrTake, rdValid, done, nackErr, stuckErr;
  logic sclOut, sclOe, sdaOut, sdaOe, devSclOe, devSdaOe;
  logic gotNack, gotStuck;
  logic [7:0] rdData;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // open-drain wires with pull-ups; a driven pin shows its out level
  wire scl = (sclOe ? sclOut : 1'b1) && !devSclOe;
  wire sda = (sdaOe ? sdaOut : 1'b1) && !devSdaOe;

  always #5 clk = ~clk;

  // fast bus and short stuck limit keep the run small
  smh_host #(.SCL_KHZ(400), .LOW_TIMEOUT_CYC(2000)) dut (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdRead(cmdRead),
    .cmdSetPtr(cmdSetPtr), .cmdPtr(cmdPtr), .cmdLen(cmdLen),
    .cmdReady(cmdReady), .wrData(wrData), .wrValid(wrValid),
    .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .done(done),
    .nackErr(nackErr), .stuckErr(stuckErr), .busClockPinIn(scl),
    .busClockPinOut(sclOut), .busClockPinOe(sclOe), .busDataIn(sda),
    .busDataOut(sdaOut), .busDataOe(sdaOe), .commModeStrapPin(strap));

  smh_dev_model dev (
    .scl(scl), .sda(sda), .addr(devAddr), .strap(strap),
    .holdClk(holdClk), .sclOe(devSclOe), .sdaOe(devSdaOe));

  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // one transaction: feeds wq on wrTake, gathers read bytes into rq
  task automatic run(input logic r, input logic sp, input logic [7:0] p,
    input logic [7:0] n);
    int k;
    k = 0;
    rq.delete();
    while (cmdReady !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdRead <= r;
    cmdSetPtr <= sp;
    cmdPtr <= p;
    cmdLen <= n;
    @(posedge clk);
    cmdValid <= 1'b0;
    k = 0;
    do begin
      wrValid <= (wq.size() != 0);
      if (wq.size() != 0) wrData <= wq[0];
      @(negedge clk);
      if (wrTake === 1'b1) void'(wq.pop_front());
      if (rdValid === 1'b1) rq.push_back(rdData);
      k++;
      if (done !== 1'b1) @(posedge clk);
    end while (done !== 1'b1 && k < 40000);
    chk("done", 8'h01, {7'h00, done});
    gotNack = nackErr;
    gotStuck = stuckErr;
    @(posedge clk);
    wrValid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset();
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("clkOe", 8'h00, {7'h00, sclOe});
    chk("datOe", 8'h00, {7'h00, sdaOe});
    chk("ready", 8'h00, {7'h00, cmdReady});
    @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic t_write();
    wq = {8'ha5};
    run(1'b0, 1'b0, 8'h11, 8'h01);
    chk("wrNack", 8'h00, {7'h00, gotNack});
    chk("reg11", 8'ha5, dev.regs[8'h11]);
    chk("addrW", 8'hae, dev.addrByte);
  endtask

  task automatic t_read();
    run(1'b1, 1'b1, 8'h11, 8'h01);
    chk("rdCnt", 8'h01, 8'(rq.size()));
    chk("rd0", 8'ha5, rq[0]);
    chk("hostAck", 8'h00, 8'(dev.ackCnt));
    chk("addrR", 8'haf, dev.addrByte);
  endtask

  // block write across the top of the map
  task automatic t_block_write();
    wq = {8'h01, 8'h02, 8'h03};
    run(1'b0, 1'b0, 8'hfe, 8'h03);
    chk("regFe", 8'h01, dev.regs[8'hfe]);
    chk("regFf", 8'h02, dev.regs[8'hff]);
    chk("reg00", 8'h03, dev.regs[8'h00]);
    chk("ptrW", 8'h01, dev.ptr);
  endtask

  task automatic t_block_read();
    run(1'b1, 1'b1, 8'hfe, 8'h03);
    chk("rdCnt", 8'h03, 8'(rq.size()));
    for (int i = 0; i < 3; i++) chk("rdB", 8'(i + 1), rq[i]);
    chk("hostAck", 8'h02, 8'(dev.ackCnt));
  endtask

  // pointer-only write, then a receive that rereads the same place
  task automatic t_ptr_only();
    dev.regs[8'h40] = 8'h77;
    run(1'b0, 1'b0, 8'h40, 8'h00);
    chk("ptrSet", 8'h40, dev.ptr);
    chk("reg40", 8'h77, dev.regs[8'h40]);
    run(1'b1, 1'b0, 8'h00, 8'h01);
    chk("recv", 8'h77, rq[0]);
    chk("ptrKeep", 8'h40, dev.ptr);
  endtask

  task automatic t_nack();
    devAddr <= 7'h56;
    wq = {8'h99};
    run(1'b0, 1'b0, 8'h11, 8'h01);
    chk("nack", 8'h01, {7'h00, gotNack});
    chk("reg11", 8'ha5, dev.regs[8'h11]);
    wq.delete();
    devAddr <= 7'h57;
  endtask

  task automatic t_stretch();
    wq = {8'h5c};
    fork
      run(1'b0, 1'b0, 8'h30, 8'h01);
      begin
        repeat (3000) @(posedge clk);
        holdClk <= 1'b1;
        repeat (300) @(posedge clk);
        holdClk <= 1'b0;
      end
    join
    chk("stNack", 8'h00, {7'h00, gotNack});
    chk("reg30", 8'h5c, dev.regs[8'h30]);
  endtask

  // a strapped device must see no traffic at all
  task automatic t_strap();
    @(posedge clk);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    cmdValid <= 1'b1;
    repeat (300) @(negedge clk);
    chk("ready", 8'h00, {7'h00, cmdReady});
    chk("clkOe", 8'h00, {7'h00, sclOe});
    @(posedge clk);
    cmdValid <= 1'b0;
    strap <= 1'b0;
  endtask

  // runs last: the frame is abandoned without a stop
  task automatic t_stuck();
    wq = {8'h11};
    fork
      run(1'b0, 1'b0, 8'h50, 8'h01);
      begin
        repeat (1500) @(posedge clk);
        holdClk <= 1'b1;
        repeat (2600) @(posedge clk);
        holdClk <= 1'b0;
      end
    join
    chk("stuck", 8'h01, {7'h00, gotStuck});
  endtask

  // hang guard sized above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    t_reset();
    t_write();
    t_read();
    t_block_write();
    t_block_read();
    t_ptr_only();
    t_nack();
    t_stretch();
    t_strap();
    t_stuck();
    end_of_test();
  end
endmodule
